// File: verilog/aec_pkg.sv
package aec_pkg;
  // ---------------------------------------------------------------
  // register offsets
  // ---------------------------------------------------------------
  localparam logic [4:0] OFS_CTRL_A   = 5'h00;
  localparam logic [4:0] OFS_EV_CTRL  = 5'h03;
  localparam logic [4:0] OFS_IE_CLR   = 5'h04;
  localparam logic [4:0] OFS_IE_SET   = 5'h05;
  localparam logic [4:0] OFS_IFLAG    = 5'h06;
  localparam logic [4:0] OFS_INCTRL   = 5'h08;
  localparam logic [4:0] OFS_CTRL_C   = 5'h09;
  localparam logic [4:0] OFS_AVG      = 5'h0a;
  localparam logic [4:0] OFS_SAMP     = 5'h0b;
  localparam logic [4:0] OFS_WIN_LO   = 5'h0c;
  localparam logic [4:0] OFS_WIN_HI   = 5'h0d;
  localparam logic [4:0] OFS_GAIN     = 5'h0e;
  localparam logic [4:0] OFS_OFFSET   = 5'h0f;
  localparam logic [4:0] OFS_SW_TRIG  = 5'h10;
  localparam logic [4:0] OFS_SYNCBUSY = 5'h11;
  localparam logic [4:0] OFS_RESULT   = 5'h12;
  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int B_SOFT_RESET  = 0;
  localparam int B_ENABLE      = 1;
  localparam int B_FOLLOWER_EN = 5;
  localparam int B_RUN_STDBY   = 6;
  localparam int B_ON_REQUEST  = 7;
  localparam int B_FLUSH_EI    = 0;
  localparam int B_START_EI    = 1;
  localparam int B_FLUSH_INV   = 2;
  localparam int B_RESULT_RDY  = 0;
  localparam int B_OVERRUN     = 1;
  localparam int B_WINDOW_MON  = 2;
  localparam int B_WIN_EN      = 0;
  localparam int B_SW_START    = 0;
  localparam int B_SW_FLUSH    = 1;
  // ---------------------------------------------------------------
  // reset values and counts
  // ---------------------------------------------------------------
  localparam logic [7:0]  RST_IE      = 8'h00;
  localparam logic [15:0] RST_WORD    = 16'h0000;
  localparam int          SYNC_CYC    = 3;
  localparam real         CLK_NS      = 25.0;
  localparam real         STARTUP_NS  = 1000.0;
  localparam int          STARTUP_CYC = int'($ceil(STARTUP_NS / CLK_NS));
endpackage : aec_pkg

// File: verilog/aec_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
// What this block does
// (R1) follower enabled via master control register
// (R2) master events forwarded to follower
// (R3) any incoming event triggers enabled action
// (R4) simultaneous flush beats start
// (R5) enable, standby and on-request select run
// (R6) on-request powers analog off after conversion
// (R7) soft reset and enable writes synchronized
// (R8) listed config register writes synchronized
// (R9) flush invert bit inverts flush input
// (R10) start enable lets events start conversion
// (R11) flush enable aborts and restarts conversion
// (R12) follower mode ignores own event bits
// (R13) write one clears interrupt enable bit
// (R14) clear and set share enable state
// (R15) flag with enable raises interrupt
// (R16) result ready enable behaves the same
module aec_ctrl #(
  parameter int N_EV = 2,
  parameter int RW   = 12
) (
  input  wire logic          MCLK_I,       // 40 MHz clock
  input  wire logic          RESETN_I,     // async reset, low
  input  wire logic [4:0]    ADDR_I,       // register index
  input  wire logic [15:0]   WDATA_I,      // write data
  input  wire logic          WR_I,         // write strobe
  input  wire logic          RD_I,         // read strobe
  output logic      [15:0]   RDATA_O,      // read data, next cycle
  input  wire logic [N_EV-1:0] START_EV_I, // start event pulses
  input  wire logic [N_EV-1:0] FLUSH_EV_I, // flush event levels
  input  wire logic          STANDBY_I,    // system in standby
  input  wire logic          PEER_ENABLE_I,// enable from master
  input  wire logic          PEER_START_I, // start from master
  input  wire logic          PEER_FLUSH_I, // flush from master
  output logic               PEER_ENABLE_O,// enable to follower
  output logic               PEER_START_O, // start to follower
  output logic               PEER_FLUSH_O, // flush to follower
  output logic               ANA_PWR_O,    // analog power on
  output logic               ANA_SOC_O,    // conversion start pulse
  input  wire logic          ANA_EOC_I,    // conversion done pulse
  input  wire logic [RW-1:0] ANA_RES_I,    // conversion result
  output logic               CLK_REQ_O,    // clock / wake request
  output logic               IRQ_O         // level interrupt
);

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  typedef enum logic [1:0] { ST_OFF, ST_WARM, ST_READY, ST_CONV } aec_state_e;

  logic          soft_rst_q, enable_q, foll_en_q, run_stdby_q, on_req_q;
  logic [2:0]    ev_ctrl_q;
  logic [2:0]    ie_q, flag_q;
  logic [15:0]   inctrl_q, ctrl_c_q;
  logic [7:0]    avg_q, samp_q;
  logic [RW-1:0] win_lo_q, win_hi_q, gain_q, offs_q, result_q;
  logic [1:0]    sw_trig_q;
  logic          pend_q;
  logic [4:0]    pend_addr_q;
  logic [15:0]   pend_data_q;
  logic [3:0]    sync_cnt_q;
  logic          commit;
  logic          flush_lvl, flush_lvl_q;
  logic          own_start, own_flush, start_ev, flush_ev, eff_en;
  logic          run_ok;
  aec_state_e    state_q;
  logic [15:0]   warm_cnt_q;
  logic          start_pend_q;
  logic          soc_q;
  logic          done_ok, win_hit;
  logic [2:0]    flag_set;
  logic          wr_sync;

  // ---------------------------------------------------------------
  // write synchronisation
  // ---------------------------------------------------------------
  // a write to a synced register (or to control_a, for its enable and
  // soft reset bits) is held for SYNC_CYC cycles before it lands;
  // further synced writes while busy are dropped, software polls busy
  assign wr_sync = WR_I && (ADDR_I == aec_pkg::OFS_CTRL_A ||
                   (ADDR_I >= aec_pkg::OFS_INCTRL && ADDR_I <= aec_pkg::OFS_SW_TRIG));
  assign commit  = pend_q && (sync_cnt_q == 4'(aec_pkg::SYNC_CYC - 1));

  always_ff @(posedge MCLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      pend_q      <= 1'b0;
      pend_addr_q <= 5'h00;
      pend_data_q <= 16'h0000;
      sync_cnt_q  <= 4'h0;
    end else if (!pend_q && wr_sync) begin       // [R7] [R8]
      pend_q      <= 1'b1;
      pend_addr_q <= ADDR_I;
      pend_data_q <= WDATA_I;
      sync_cnt_q  <= 4'h0;
    end else if (commit) begin
      pend_q      <= 1'b0;
    end else if (pend_q) begin
      sync_cnt_q  <= sync_cnt_q + 4'h1;
    end
  end

  // ---------------------------------------------------------------
  // control_a
  // ---------------------------------------------------------------
  // soft reset returns control, config, event control, flag and enable registers to reset; result_q keeps its value; it self-clears
  always_ff @(posedge MCLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      soft_rst_q  <= 1'b0;
      enable_q    <= 1'b0;
      foll_en_q   <= 1'b0;
      run_stdby_q <= 1'b0;
      on_req_q    <= 1'b0;
    end else if (soft_rst_q) begin
      soft_rst_q  <= 1'b0;
      enable_q    <= 1'b0;
      foll_en_q   <= 1'b0;
      run_stdby_q <= 1'b0;
      on_req_q    <= 1'b0;
    end else begin
      if (WR_I && ADDR_I == aec_pkg::OFS_CTRL_A) begin
        foll_en_q   <= WDATA_I[aec_pkg::B_FOLLOWER_EN];
        run_stdby_q <= WDATA_I[aec_pkg::B_RUN_STDBY];
        on_req_q    <= WDATA_I[aec_pkg::B_ON_REQUEST];
      end
      if (commit && pend_addr_q == aec_pkg::OFS_CTRL_A) begin   // [R7]
        soft_rst_q <= pend_data_q[aec_pkg::B_SOFT_RESET];
        enable_q   <= pend_data_q[aec_pkg::B_ENABLE];
      end
    end
  end

  // ---------------------------------------------------------------
  // synced configuration registers
  // ---------------------------------------------------------------
  always_ff @(posedge MCLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      inctrl_q <= aec_pkg::RST_WORD;
      ctrl_c_q <= aec_pkg::RST_WORD;
      avg_q    <= 8'h00;
      samp_q   <= 8'h00;
      win_lo_q <= '0;
      win_hi_q <= '0;
      gain_q   <= '0;
      offs_q   <= '0;
    end else if (soft_rst_q) begin
      inctrl_q <= aec_pkg::RST_WORD;
      ctrl_c_q <= aec_pkg::RST_WORD;
      avg_q    <= 8'h00;
      samp_q   <= 8'h00;
      win_lo_q <= '0;
      win_hi_q <= '0;
      gain_q   <= '0;
      offs_q   <= '0;
    end else if (commit) begin                   // [R8]
      case (pend_addr_q)
        aec_pkg::OFS_INCTRL: inctrl_q <= pend_data_q;
        aec_pkg::OFS_CTRL_C: ctrl_c_q <= pend_data_q;
        aec_pkg::OFS_AVG:    avg_q    <= pend_data_q[7:0];
        aec_pkg::OFS_SAMP:   samp_q   <= pend_data_q[7:0];
        aec_pkg::OFS_WIN_LO: win_lo_q <= pend_data_q[RW-1:0];
        aec_pkg::OFS_WIN_HI: win_hi_q <= pend_data_q[RW-1:0];
        aec_pkg::OFS_GAIN:   gain_q   <= pend_data_q[RW-1:0];
        aec_pkg::OFS_OFFSET: offs_q   <= pend_data_q[RW-1:0];
        default: ;
      endcase
    end
  end

  // software trigger: one-cycle request after sync, then self-clears
  always_ff @(posedge MCLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      sw_trig_q <= 2'h0;
    end else if (commit && pend_addr_q == aec_pkg::OFS_SW_TRIG && !soft_rst_q) begin
      sw_trig_q <= pend_data_q[1:0];             // [R8]
    end else begin
      sw_trig_q <= 2'h0;
    end
  end

  // ---------------------------------------------------------------
  // event control (not synced)
  // ---------------------------------------------------------------
  always_ff @(posedge MCLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      ev_ctrl_q <= 3'h0;
    end else if (soft_rst_q) begin
      ev_ctrl_q <= 3'h0;
    end else if (WR_I && ADDR_I == aec_pkg::OFS_EV_CTRL) begin
      ev_ctrl_q <= WDATA_I[2:0];
    end
  end

  // ---------------------------------------------------------------
  // event handling
  // ---------------------------------------------------------------
  // flush is taken on the rising edge of the (possibly inverted) level,
  // so inversion turns a falling input edge into the trigger
  assign flush_lvl = |(FLUSH_EV_I ^ {N_EV{ev_ctrl_q[aec_pkg::B_FLUSH_INV]}}); // [R9] [R3]

  always_ff @(posedge MCLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      flush_lvl_q <= 1'b0;
    end else begin
      flush_lvl_q <= flush_lvl;
    end
  end

  assign own_flush = ev_ctrl_q[aec_pkg::B_FLUSH_EI] && flush_lvl && !flush_lvl_q; // [R11]
  assign own_start = ev_ctrl_q[aec_pkg::B_START_EI] && (|START_EV_I);           // [R10] [R3]

  // follower mode: master supplies enable and events, own bits ignored
  assign eff_en   = foll_en_q ? PEER_ENABLE_I : enable_q;                    // [R1]
  assign flush_ev = (foll_en_q ? PEER_FLUSH_I : own_flush) ||
                    sw_trig_q[aec_pkg::B_SW_FLUSH];                          // [R12]
  assign start_ev = (foll_en_q ? PEER_START_I : own_start) ||
                    sw_trig_q[aec_pkg::B_SW_START];                          // [R2]

  // master side: processed events and enable feed the follower
  assign PEER_ENABLE_O = enable_q;                                           // [R1]
  assign PEER_FLUSH_O  = own_flush;                                          // [R2]
  assign PEER_START_O  = own_start;                                          // [R2]

  // ---------------------------------------------------------------
  // sleep behaviour and sequencer
  // ---------------------------------------------------------------
  assign run_ok = eff_en && (run_stdby_q || !STANDBY_I);                     // [R5]

  always_ff @(posedge MCLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      state_q      <= ST_OFF;
      warm_cnt_q   <= 16'h0000;
      start_pend_q <= 1'b0;
      soc_q        <= 1'b0;
    end else begin
      soc_q <= 1'b0;
      if (!run_ok || soft_rst_q) begin
        state_q      <= ST_OFF;
        start_pend_q <= 1'b0;
      end else begin
        case (state_q)
          ST_OFF: begin
            // on request: stay dark until a start or flush arrives
            if (!on_req_q || start_ev || flush_ev) begin             // [R5] [R6]
              state_q      <= ST_WARM;
              warm_cnt_q   <= 16'h0000;
              start_pend_q <= start_ev || flush_ev;
            end
          end
          ST_WARM: begin
            if (start_ev || flush_ev) begin
              start_pend_q <= 1'b1;
            end
            if (warm_cnt_q == 16'(aec_pkg::STARTUP_CYC - 1)) begin   // [R6]
              if (start_pend_q || start_ev || flush_ev) begin
                state_q <= ST_CONV;
                soc_q   <= 1'b1;
              end else begin
                state_q <= ST_READY;
              end
              start_pend_q <= 1'b0;
            end else begin
              warm_cnt_q <= warm_cnt_q + 16'h0001;
            end
          end
          ST_READY: begin
            if (on_req_q) begin
              state_q <= ST_OFF;
            end else if (start_ev || flush_ev) begin
              state_q <= ST_CONV;
              soc_q   <= 1'b1;
            end
          end
          ST_CONV: begin
            // flush wins over start and over the finishing result
            if (flush_ev) begin                                      // [R4] [R11]
              soc_q <= 1'b1;
            end else if (ANA_EOC_I) begin
              state_q <= on_req_q ? ST_OFF : ST_READY;               // [R6]
            end
          end
          default: state_q <= ST_OFF;
        endcase
      end
    end
  end

  assign ANA_PWR_O = (state_q != ST_OFF);
  assign ANA_SOC_O = soc_q;
  assign CLK_REQ_O = (state_q != ST_OFF) || (run_ok && !on_req_q);

  // ---------------------------------------------------------------
  // result and flags
  // ---------------------------------------------------------------
  // a flushed conversion's done pulse is dropped
  assign done_ok = (state_q == ST_CONV) && ANA_EOC_I && !flush_ev;
  assign win_hit = ctrl_c_q[aec_pkg::B_WIN_EN] &&
                   (ANA_RES_I < win_lo_q || ANA_RES_I > win_hi_q);
  assign flag_set = {done_ok && win_hit,
                     done_ok && flag_q[aec_pkg::B_RESULT_RDY],
                     done_ok};

  always_ff @(posedge MCLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      result_q <= '0;
    end else if (done_ok) begin
      result_q <= ANA_RES_I;
    end
  end

  // set beats a same-cycle write-one clear
  always_ff @(posedge MCLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      flag_q <= 3'h0;
    end else if (soft_rst_q) begin
      flag_q <= 3'h0;
    end else if (WR_I && ADDR_I == aec_pkg::OFS_IFLAG) begin
      flag_q <= (flag_q & ~WDATA_I[2:0]) | flag_set;
    end else begin
      flag_q <= flag_q | flag_set;
    end
  end

  // ---------------------------------------------------------------
  // interrupt enables: one state, two views
  // ---------------------------------------------------------------
  always_ff @(posedge MCLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      ie_q <= aec_pkg::RST_IE[2:0];
    end else if (soft_rst_q) begin
      ie_q <= aec_pkg::RST_IE[2:0];
    end else if (WR_I && ADDR_I == aec_pkg::OFS_IE_CLR) begin
      ie_q <= ie_q & ~WDATA_I[2:0];              // [R13] [R14] [R16]
    end else if (WR_I && ADDR_I == aec_pkg::OFS_IE_SET) begin
      ie_q <= ie_q | WDATA_I[2:0];               // [R14]
    end
  end

  assign IRQ_O = |(flag_q & ie_q);               // [R15] [R16]

  // ---------------------------------------------------------------
  // read port
  // ---------------------------------------------------------------
  always_ff @(posedge MCLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      RDATA_O <= 16'h0000;
    end else if (RD_I) begin
      case (ADDR_I)
        aec_pkg::OFS_CTRL_A:   RDATA_O <= {8'h00, on_req_q, run_stdby_q, foll_en_q,
                                           3'h0, enable_q, soft_rst_q};
        aec_pkg::OFS_EV_CTRL:  RDATA_O <= {13'h0000, ev_ctrl_q};
        aec_pkg::OFS_IE_CLR,
        aec_pkg::OFS_IE_SET:   RDATA_O <= {13'h0000, ie_q};        // [R14]
        aec_pkg::OFS_IFLAG:    RDATA_O <= {13'h0000, flag_q};
        aec_pkg::OFS_INCTRL:   RDATA_O <= inctrl_q;
        aec_pkg::OFS_CTRL_C:   RDATA_O <= ctrl_c_q;
        aec_pkg::OFS_AVG:      RDATA_O <= {8'h00, avg_q};
        aec_pkg::OFS_SAMP:     RDATA_O <= {8'h00, samp_q};
        aec_pkg::OFS_WIN_LO:   RDATA_O <= 16'(win_lo_q);
        aec_pkg::OFS_WIN_HI:   RDATA_O <= 16'(win_hi_q);
        aec_pkg::OFS_GAIN:     RDATA_O <= 16'(gain_q);
        aec_pkg::OFS_OFFSET:   RDATA_O <= 16'(offs_q);
        aec_pkg::OFS_SYNCBUSY: RDATA_O <= {15'h0000, pend_q};
        aec_pkg::OFS_RESULT:   RDATA_O <= 16'(result_q);
        default:               RDATA_O <= 16'h0000;
      endcase
    end else begin
      RDATA_O <= 16'h0000;
    end
  end

endmodule : aec_ctrl
`default_nettype wire

// File: bench/aec_ctrl_chk.sv
`timescale 1ns/1ps
`default_nettype none
// ---------------------------------------------
// port-level checks on the converter control
// ---------------------------------------------
module aec_ctrl_chk #(
  parameter int N_EV = 2
) (
  input wire logic            MCLK_I,       // clock
  input wire logic            RESETN_I,     // reset, low
  input wire logic            WR_I,         // write strobe
  input wire logic            RD_I,         // read strobe
  input wire logic [15:0]     RDATA_O,      // read data
  input wire logic [N_EV-1:0] START_EV_I,   // start events
  input wire logic [N_EV-1:0] FLUSH_EV_I,   // flush events
  input wire logic            PEER_START_I, // start from master
  input wire logic            PEER_FLUSH_I, // flush from master
  input wire logic            PEER_START_O, // own start
  input wire logic            PEER_FLUSH_O, // own flush
  input wire logic            ANA_PWR_O,    // analog power
  input wire logic            ANA_SOC_O,    // start pulse
  input wire logic            ANA_EOC_I,    // done pulse
  input wire logic            IRQ_O         // interrupt
);
  default clocking cb @(posedge MCLK_I); endclocking
  default disable iff (!RESETN_I);
  logic [3:0] wr_age_q; // cycles since last write
  // saturating age, so irq checks allow for write latency
  always_ff @(posedge MCLK_I or negedge RESETN_I) begin
    if (!RESETN_I) wr_age_q <= 4'hf;
    else if (WR_I) wr_age_q <= 4'h0;
    else if (wr_age_q != 4'hf) wr_age_q <= wr_age_q + 4'h1;
  end
  sequence s_soc_once; ANA_SOC_O ##1 !ANA_SOC_O; endsequence
  sequence s_warm; !ANA_SOC_O [*8]; endsequence
  a_rdata_idle: assert property (!$past(RD_I) |-> RDATA_O == 16'h0000)
    else $error("read data not zero outside answer");
  a_soc_pulse: assert property (ANA_SOC_O |-> s_soc_once)
    else $error("start pulse longer than one cycle");
  a_soc_power: assert property (ANA_SOC_O |-> ANA_PWR_O)
    else $error("start pulse without analog power");
  a_warm_wait: assert property ($rose(ANA_PWR_O) |-> s_warm)
    else $error("start pulse inside warm-up");
  a_start_cause: assert property (PEER_START_O |-> (|START_EV_I) || PEER_START_I)
    else $error("start event out with no event in");
  a_flush_cause: assert property (PEER_FLUSH_O |-> (FLUSH_EV_I != $past(FLUSH_EV_I))
    || PEER_FLUSH_I || wr_age_q <= 4'h1)
    else $error("flush event out with no level change");
  a_irq_rise: assert property ($rose(IRQ_O) |-> $past(ANA_EOC_I) || $past(ANA_EOC_I, 2)
    || wr_age_q <= 4'h1)
    else $error("interrupt rose without result or write");
  a_irq_fall: assert property ($fell(IRQ_O) |-> wr_age_q <= 4'h7)
    else $error("interrupt fell without a write");
endmodule : aec_ctrl_chk
bind aec_ctrl aec_ctrl_chk #(.N_EV(N_EV)) aec_ctrl_chk_inst (
  .MCLK_I(MCLK_I), .RESETN_I(RESETN_I), .WR_I(WR_I), .RD_I(RD_I), .RDATA_O(RDATA_O),
  .START_EV_I(START_EV_I), .FLUSH_EV_I(FLUSH_EV_I), .PEER_START_I(PEER_START_I),
  .PEER_FLUSH_I(PEER_FLUSH_I), .PEER_START_O(PEER_START_O), .PEER_FLUSH_O(PEER_FLUSH_O),
  .ANA_PWR_O(ANA_PWR_O), .ANA_SOC_O(ANA_SOC_O), .ANA_EOC_I(ANA_EOC_I), .IRQ_O(IRQ_O));
`default_nettype wire

// File: bench/aec_ana_model.sv
`timescale 1ns/1ps
`default_nettype none
module aec_ana_model #(
  parameter int DLY = 20
) (
  input  wire logic        clk_i,   // clock
  input  wire logic        rst_n_i, // reset, low
  input  wire logic        soc_i,   // start pulse
  input  wire logic [11:0] val_i,   // value to convert
  output logic             eoc_o,   // done pulse
  output logic [11:0]      res_o    // result, valid with eoc
);
  int cnt_q;
  // a new start reloads the count, so a flush discards the old one
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_q <= 0;
      eoc_o <= 1'b0;
      res_o <= 12'h000;
    end else begin
      eoc_o <= (cnt_q == 1) && !soc_i;
      res_o <= ((cnt_q == 1) && !soc_i) ? val_i : ~res_o; // toggles when not valid
      if (soc_i) cnt_q <= DLY;
      else if (cnt_q != 0) cnt_q <= cnt_q - 1;
    end
  end
endmodule : aec_ana_model
`default_nettype wire

// File: bench/aec_ctrl_tb.sv
`timescale 1ns/1ps
`default_nettype none
module aec_ctrl_tb;
  logic        clk, rstn, wr_s, rd_s, stby, pen_i, pst_i, pfl_i;
  logic [4:0]  addr;
  logic [15:0] wdata, rdata;
  logic [1:0]  sev, fev;
  logic        pen_o, pst_o, pfl_o, pwr, soc, eoc, creq, irq;
  logic [11:0] res;
  int          error_cnt, n_checks, c;
  aec_ctrl #(.N_EV(2), .RW(12)) aec_ctrl_inst (.MCLK_I(clk), .RESETN_I(rstn),
    .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr_s), .RD_I(rd_s), .RDATA_O(rdata),
    .START_EV_I(sev), .FLUSH_EV_I(fev), .STANDBY_I(stby), .PEER_ENABLE_I(pen_i),
    .PEER_START_I(pst_i), .PEER_FLUSH_I(pfl_i), .PEER_ENABLE_O(pen_o),
    .PEER_START_O(pst_o), .PEER_FLUSH_O(pfl_o), .ANA_PWR_O(pwr), .ANA_SOC_O(soc),
    .ANA_EOC_I(eoc), .ANA_RES_I(res), .CLK_REQ_O(creq), .IRQ_O(irq));
  aec_ana_model #(.DLY(20)) aec_ana_model_inst (.clk_i(clk), .rst_n_i(rstn),
    .soc_i(soc), .val_i(12'h005), .eoc_o(eoc), .res_o(res));
  // ---------------------------------------------
  // clock and shared tasks
  // ---------------------------------------------
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  task automatic ck(input bit ok, input string m);
    n_checks++;
    if (!ok) begin
      error_cnt++;
      $display("MISMATCH %0t %s", $time, m);
    end
  endtask : ck
  task automatic final_report;
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : final_report
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a; wdata <= d; wr_s <= 1'b1;
    @(posedge clk);
    wr_s <= 1'b0;
  endtask : wr
  task automatic rd(input logic [4:0] a, input logic [15:0] e);
    @(posedge clk);
    addr <= a; rd_s <= 1'b1;
    @(posedge clk);
    rd_s <= 1'b0;
    @(negedge clk);
    ck(rdata === e, "read data");
  endtask : rd
  task automatic sy;
    repeat (4) @(posedge clk); // sync delay plus one
  endtask : sy
  task automatic ev(input logic [1:0] s, input logic [1:0] f);
    @(posedge clk);
    sev <= s; fev <= f;
    @(posedge clk);
    sev <= 2'b00;
  endtask : ev
  // a start that never comes ends the run at once
  task automatic soc_in(input int n);
    c = 0;
    do begin
      @(negedge clk);
      c++;
    end while (soc !== 1'b1 && c < n);
    if (soc !== 1'b1) begin
      error_cnt++;
      $display("MISMATCH %0t no conversion start", $time);
      final_report();
    end else begin
      n_checks++;
    end
  endtask : soc_in
  task automatic no_soc(input int n);
    c = 0;
    repeat (n) begin
      @(negedge clk);
      if (soc === 1'b1) c++;
    end
    ck(c == 0, "unexpected conversion start");
  endtask : no_soc
  // ---------------------------------------------
  // scenarios
  // ---------------------------------------------
  task automatic t_regs;
    rd(aec_pkg::OFS_IE_CLR, 16'h0000);
    rd(aec_pkg::OFS_EV_CTRL, 16'h0000);
    wr(5'h1f, 16'hffff);
    rd(5'h1f, 16'h0000);
    wr(aec_pkg::OFS_IE_SET, 16'h0007);
    rd(aec_pkg::OFS_IE_CLR, 16'h0007);
    wr(aec_pkg::OFS_IE_CLR, 16'h0002);
    rd(aec_pkg::OFS_IE_SET, 16'h0005);
    wr(aec_pkg::OFS_IE_CLR, 16'h0000);
    rd(aec_pkg::OFS_IE_SET, 16'h0005);
    wr(aec_pkg::OFS_IE_CLR, 16'h0005);
    rd(aec_pkg::OFS_IE_SET, 16'h0000);
    wr(aec_pkg::OFS_WIN_LO, 16'h0abc);
    rd(aec_pkg::OFS_WIN_LO, 16'h0000);
    sy();
    rd(aec_pkg::OFS_WIN_LO, 16'h0abc);
    $display("test regs done");
  endtask : t_regs
  task automatic t_events;
    ev(2'b10, 2'b00);
    no_soc(50);
    wr(aec_pkg::OFS_CTRL_A, 16'h0002);
    @(negedge clk);
    ck(pen_o === 1'b0, "enable took effect early");
    sy();
    ck(pen_o === 1'b1, "enable not forwarded");
    ck(creq === 1'b1, "no clock request while enabled");
    repeat (45) @(posedge clk);
    ev(2'b10, 2'b00);
    no_soc(5);
    wr(aec_pkg::OFS_EV_CTRL, 16'h0003);
    ev(2'b10, 2'b00);
    soc_in(3);
    repeat (5) @(posedge clk);
    ev(2'b01, 2'b00);
    no_soc(3);
    ev(2'b01, 2'b01);
    soc_in(3);
    repeat (25) @(posedge clk);
    wr(aec_pkg::OFS_EV_CTRL, 16'h0005);
    ev(2'b00, 2'b11);
    no_soc(3);
    ev(2'b00, 2'b00);
    soc_in(3);
    repeat (25) @(posedge clk);
    wr(aec_pkg::OFS_EV_CTRL, 16'h0000);
    ev(2'b00, 2'b11);
    no_soc(3);
    ev(2'b00, 2'b00);
    wr(aec_pkg::OFS_SW_TRIG, 16'h0001);
    soc_in(6);
    repeat (25) @(posedge clk);
    $display("test events done");
  endtask : t_events
  task automatic t_irq;
    wr(aec_pkg::OFS_IFLAG, 16'h0007);
    wr(aec_pkg::OFS_CTRL_C, 16'h0001);
    sy();
    wr(aec_pkg::OFS_IE_SET, 16'h0004);
    wr(aec_pkg::OFS_EV_CTRL, 16'h0002);
    ev(2'b01, 2'b00);
    soc_in(3);
    repeat (25) @(posedge clk);
    ck(irq === 1'b1, "window interrupt missing");
    rd(aec_pkg::OFS_IFLAG, 16'h0005);
    wr(aec_pkg::OFS_IE_CLR, 16'h0004);
    @(negedge clk);
    ck(irq === 1'b0, "interrupt not disabled");
    ev(2'b01, 2'b00);
    soc_in(3);
    repeat (25) @(posedge clk);
    rd(aec_pkg::OFS_IFLAG, 16'h0007);
    wr(aec_pkg::OFS_IE_SET, 16'h0002);
    @(negedge clk);
    ck(irq === 1'b1, "overrun interrupt missing");
    wr(aec_pkg::OFS_IFLAG, 16'h0007);
    @(negedge clk);
    ck(irq === 1'b0, "flags not cleared");
    $display("test irq done");
  endtask : t_irq
  task automatic t_modes;
    pen_i <= 1'b1;
    wr(aec_pkg::OFS_CTRL_A, 16'h0022);
    sy();
    repeat (45) @(posedge clk);
    ev(2'b11, 2'b00);
    no_soc(3);
    @(posedge clk);
    pst_i <= 1'b1;
    @(posedge clk);
    pst_i <= 1'b0;
    soc_in(3);
    @(posedge clk);
    pfl_i <= 1'b1;
    @(posedge clk);
    pfl_i <= 1'b0;
    soc_in(3);
    repeat (25) @(posedge clk);
    pen_i <= 1'b0;
    repeat (4) @(posedge clk);
    ck(pwr === 1'b0, "follower runs without master enable");
    wr(aec_pkg::OFS_CTRL_A, 16'h0002);
    sy();
    stby <= 1'b1;
    repeat (4) @(posedge clk);
    ck(pwr === 1'b0, "runs in standby");
    ev(2'b01, 2'b00);
    no_soc(50);
    wr(aec_pkg::OFS_CTRL_A, 16'h0042);
    sy();
    repeat (45) @(posedge clk);
    ev(2'b01, 2'b00);
    soc_in(3);
    repeat (25) @(posedge clk);
    wr(aec_pkg::OFS_CTRL_A, 16'h00c2);
    sy();
    repeat (50) @(posedge clk);
    ck(pwr === 1'b0, "analog on while idle");
    ck(creq === 1'b0, "clock requested while idle");
    ev(2'b01, 2'b00);
    soc_in(60);
    ck(c > aec_pkg::STARTUP_CYC, "no warm-up before start");
    repeat (25) @(posedge clk);
    ck(pwr === 1'b0, "analog on after conversion");
    stby <= 1'b0;
    $display("test modes done");
  endtask : t_modes
  task automatic t_softrst;
    wr(aec_pkg::OFS_IE_SET, 16'h0007);
    wr(aec_pkg::OFS_CTRL_A, 16'h0001);
    rd(aec_pkg::OFS_IE_SET, 16'h0007);
    sy();
    sy();
    rd(aec_pkg::OFS_IE_SET, 16'h0000);
    rd(aec_pkg::OFS_CTRL_A, 16'h0000);
    $display("test soft reset done");
  endtask : t_softrst
  // reset, then every scenario in turn
  initial begin
    {rstn, wr_s, rd_s, stby, pen_i, pst_i, pfl_i} = '0;
    {addr, wdata, sev, fev} = '0;
    error_cnt = 0;
    n_checks = 0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    t_regs();
    t_events();
    t_irq();
    t_modes();
    t_softrst();
    final_report();
  end
endmodule : aec_ctrl_tb
`default_nettype wire
